// ### hdl/wdp_pkg.sv
// package: register map, field layout and timing constants of the postscaled watchdog
`default_nettype none
package wdp_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] WDP_OFF_SWCTL = 4'h0; // watchdog_software_control
    localparam logic [3:0] WDP_OFF_CFGH = 4'h1; // watchdog_configuration_high
    localparam logic [3:0] WDP_OFF_OSCCTL = 4'h2; // oscillator_control_reg
    localparam logic [3:0] WDP_OFF_STATUS = 4'h3; // sticky event flags
    localparam logic [3:0] WDP_OFF_MASK = 4'h4; // interrupt mask
    localparam logic [3:0] WDP_OFF_CMD = 4'h5; // instruction strobes
    // field positions
    localparam int WDP_SWEN_BIT = 0; // sw_watchdog_enable
    localparam int WDP_CFGEN_BIT = 0; // cfg_watchdog_enable
    localparam int WDP_PS_LSB = 1; // postscale_select low bit
    localparam int WDP_OSC_LSB = 4; // osc_freq_select low bit
    localparam int WDP_ST_RST = 0; // time-out while running
    localparam int WDP_ST_WAKE = 1; // time-out while asleep
    localparam int WDP_CMD_CLR = 0; // clear_watchdog_instr
    localparam int WDP_CMD_SLEEP = 1; // sleep instruction
    localparam int WDP_CMD_WAKE = 2; // leave sleep
    // reset values
    localparam logic [7:0] WDP_SWCTL_RST = 8'h00;
    localparam logic [7:0] WDP_CFGH_RST = 8'h1F;
    localparam logic [7:0] WDP_OSCCTL_RST = 8'h00;
    localparam logic [1:0] WDP_FLAG_RST = 2'h0;
    // timing: base period and oscillator rate
    localparam int WDP_BASE_MS = 4; // nominal base period
    localparam int WDP_LFOSC_HZ = 31000; // low_freq_internal_osc nominal rate
    localparam int WDP_BASE_TICKS = WDP_LFOSC_HZ * WDP_BASE_MS / 1000; // osc ticks per base period
    localparam int WDP_POST_BITS = 16; // postscaler width
endpackage
`default_nettype wire

// ### hdl/wdp_sync.sv
// two-flop synchroniser for a level from another clock
`default_nettype none
module wdp_sync (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic din, // asynchronous level
    output logic dout // synchronised level
);
    logic s1_q; // first stage, read only by the second
    logic s2_q; // second stage
    // plain two-stage shift
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule
`default_nettype wire

// ### hdl/wdp_post.sv
// base-period divider and 16-bit postscaler with tap select
`default_nettype none
module wdp_post
    import wdp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic run, // watchdog counting
    input wire logic tick, // one-cycle pulse per oscillator edge
    input wire logic clear, // clear counter and postscaler
    input wire logic [3:0] sel, // postscale_select
    output logic expire // one-cycle pulse at selected tap end
);
    logic [15:0] base_q, base_d; // base period counter
    logic [WDP_POST_BITS:0] post_q, post_d; // postscaler, one extra bit, which stays zero even at the top tap
    logic base_end; // base period finished this tick
    logic [WDP_POST_BITS:0] post_inc; // postscaler plus one
    // a clear in the tick cycle wins, so a serviced watchdog never times out late
    assign base_end = run && tick && !clear && (base_q == 16'(WDP_BASE_TICKS - 1));
    assign post_inc = post_q + 17'h0_0001;
    // expiry when the selected tap reaches its count of base periods
    assign expire = base_end && (post_inc == (17'h0_0001 << sel));
    // next values of both counters
    always_comb begin
        base_d = base_q;
        post_d = post_q;
        if (clear || !run) begin
            base_d = 16'h0000;
            post_d = 17'h0_0000;
        end else if (tick) begin
            if (base_end) begin
                base_d = 16'h0000;
                post_d = expire ? 17'h0_0000 : post_inc;
            end else begin
                base_d = base_q + 16'h0001;
            end
        end
    end
    // register the counters
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_q <= 16'h0000;
            post_q <= 17'h0_0000;
        end else begin
            base_q <= base_d;
            post_q <= post_d;
        end
    end
endmodule
`default_nettype wire

// ### hdl/wdp_top.sv
// postscaled watchdog timer: registers, enable logic, clears and time-out events
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`default_nettype none
module wdp_top
    import wdp_pkg::*;
(
    input wire logic clk, // system clock, 40 MHz
    input wire logic resetn, // async reset, active low
    input wire logic lf_osc_clk, // low_freq_internal_osc, asynchronous
    input wire logic clk_fail, // clock failure level, asynchronous
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    output logic lf_osc_en, // enables the oscillator source
    output logic wdt_reset, // time-out reset pulse
    output logic wdt_wake, // time-out wake-up pulse
    output logic asleep, // device in sleep
    output logic irq // level interrupt
);
    import wdp_pkg::*;
    logic [7:0] swctl_q, swctl_d; // watchdog_software_control
    logic [7:0] cfgh_q, cfgh_d; // watchdog_configuration_high
    logic [7:0] osc_q, osc_d; // oscillator_control_reg
    logic [1:0] stat_q, stat_d; // sticky time-out flags
    logic [1:0] mask_q, mask_d; // interrupt mask
    logic sleep_q, sleep_d; // sleep state
    logic [7:0] rdata_q, rdata_d; // read data register
    logic osc_s, osc_prev_q; // synchronised oscillator and its previous value
    logic fail_s; // synchronised clock failure
    logic tick; // one pulse per oscillator rising edge
    logic enabled; // watchdog running
    logic clear; // any clear cause
    logic expire; // selected tap ended
    logic wr_sw, wr_cfg, wr_osc, wr_st, wr_mk, wr_cmd; // write decodes
    logic osc_change; // frequency select really changes
    logic [1:0] ev; // events this cycle

    // bring the oscillator and failure levels into the clk domain
    wdp_sync u_sync_osc (
        .clk(clk),
        .resetn(resetn),
        .din(lf_osc_clk),
        .dout(osc_s)
    );
    wdp_sync u_sync_fail (
        .clk(clk),
        .resetn(resetn),
        .din(clk_fail),
        .dout(fail_s)
    );

    // edge of the synchronised oscillator gives the count tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
        end
    end
    assign tick = osc_s && !osc_prev_q;

    // write decodes
    assign wr_sw = wr && (addr == WDP_OFF_SWCTL);
    assign wr_cfg = wr && (addr == WDP_OFF_CFGH);
    assign wr_osc = wr && (addr == WDP_OFF_OSCCTL);
    assign wr_st = wr && (addr == WDP_OFF_STATUS);
    assign wr_mk = wr && (addr == WDP_OFF_MASK);
    assign wr_cmd = wr && (addr == WDP_OFF_CMD);

    // configuration bit wins; software bit only matters when it is clear
    assign enabled = cfgh_q[WDP_CFGEN_BIT] || swctl_q[WDP_SWEN_BIT];
    assign lf_osc_en = enabled;

    // only a write that alters the frequency select field clears
    assign osc_change = wr_osc && (wdata[7:WDP_OSC_LSB] != osc_q[7:WDP_OSC_LSB]);
    // all clear causes
    assign clear = (wr_cmd && (wdata[WDP_CMD_CLR] || wdata[WDP_CMD_SLEEP]))
        || osc_change
        || fail_s;

    // postscaler and base divider
    wdp_post u_post (
        .clk(clk),
        .resetn(resetn),
        .run(enabled),
        .tick(tick),
        .clear(clear),
        .sel(cfgh_q[WDP_PS_LSB +: 4]),
        .expire(expire)
    );

    // time-out outcome depends on sleep state
    assign wdt_reset = expire && !sleep_q;
    assign wdt_wake = expire && sleep_q;
    assign ev = {wdt_wake, wdt_reset};
    assign asleep = sleep_q;
    assign irq = |(stat_q & mask_q);

    // next register values
    always_comb begin
        swctl_d = swctl_q;
        cfgh_d = cfgh_q;
        osc_d = osc_q;
        mask_d = mask_q;
        sleep_d = sleep_q;
        rdata_d = 8'h00;
        if (wr_sw) begin
            swctl_d = {7'h00, wdata[WDP_SWEN_BIT]};
        end
        if (wr_cfg) begin
            cfgh_d = {3'h0, wdata[4:0]};
        end
        if (wr_osc) begin
            osc_d = wdata;
        end
        if (wr_mk) begin
            mask_d = wdata[1:0];
        end
        // sleep entry and exit
        if (wr_cmd && wdata[WDP_CMD_SLEEP]) begin
            sleep_d = 1'b1;
        end else if ((wr_cmd && wdata[WDP_CMD_WAKE]) || wdt_wake) begin
            sleep_d = 1'b0;
        end
        // set wins over write-one-to-clear
        stat_d = (stat_q & ~(wr_st ? wdata[1:0] : 2'h0)) | ev;
        // read mux, unmapped reads zero
        if (rd) begin
            case (addr)
                WDP_OFF_SWCTL: rdata_d = {7'h00, swctl_q[WDP_SWEN_BIT]};
                WDP_OFF_CFGH: rdata_d = cfgh_q;
                WDP_OFF_OSCCTL: rdata_d = osc_q;
                WDP_OFF_STATUS: rdata_d = {6'h00, stat_q};
                WDP_OFF_MASK: rdata_d = {6'h00, mask_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register everything
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            swctl_q <= WDP_SWCTL_RST;
            cfgh_q <= WDP_CFGH_RST;
            osc_q <= WDP_OSCCTL_RST;
            stat_q <= WDP_FLAG_RST;
            mask_q <= WDP_FLAG_RST;
            sleep_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            swctl_q <= swctl_d;
            cfgh_q <= cfgh_d;
            osc_q <= osc_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            sleep_q <= sleep_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // software enable follows a write of bit zero
    property p_swen_write;
        @(posedge clk) disable iff (!resetn)
        wr_sw |=> (swctl_q == {7'h00, $past(wdata[0])});
    endproperty
    a_swen_write: assert property (p_swen_write) else $error("software enable not stored");

    // control reads show zero above bit zero
    property p_swctl_read;
        @(posedge clk) disable iff (!resetn)
        (rd && addr == WDP_OFF_SWCTL) |=> (rdata[7:1] == 7'h00 && rdata[0] == $past(swctl_q[0]));
    endproperty
    a_swctl_read: assert property (p_swctl_read) else $error("control read wrong");

    // configuration enable overrides software bit
    property p_cfg_override;
        @(posedge clk) disable iff (!resetn)
        cfgh_q[0] |-> lf_osc_en;
    endproperty
    a_cfg_override: assert property (p_cfg_override) else $error("config enable ignored");

    // oscillator enable tracks watchdog enable
    property p_osc_en;
        @(posedge clk) disable iff (!resetn)
        lf_osc_en == (cfgh_q[0] || swctl_q[0]);
    endproperty
    a_osc_en: assert property (p_osc_en) else $error("oscillator enable wrong");

    // no expiry in the cycle after a clear instruction
    property p_clr_instr;
        @(posedge clk) disable iff (!resetn)
        (wr_cmd && wdata[0]) |=> !expire;
    endproperty
    a_clr_instr: assert property (p_clr_instr) else $error("expiry after clear");

    // frequency change clears too
    property p_osc_clear;
        @(posedge clk) disable iff (!resetn)
        osc_change |=> !expire;
    endproperty
    a_osc_clear: assert property (p_osc_clear) else $error("expiry after osc change");

    // held clock failure keeps the watchdog from expiring
    property p_fail_clear;
        @(posedge clk) disable iff (!resetn)
        fail_s |-> !expire;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("expiry during clock failure");

    // a time-out sets its sticky flag next cycle
    property p_timeout_flag;
        @(posedge clk) disable iff (!resetn)
        wdt_reset |=> stat_q[WDP_ST_RST];
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("time-out flag not set");

    // wake leaves sleep
    property p_wake;
        @(posedge clk) disable iff (!resetn)
        wdt_wake |=> !sleep_q && stat_q[WDP_ST_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("wake not taken");

    // expiry only on an oscillator tick while enabled
    property p_expire_tick;
        @(posedge clk) disable iff (!resetn)
        expire |-> (tick && enabled);
    endproperty
    a_expire_tick: assert property (p_expire_tick) else $error("expiry without tick");

    // a clear in the same cycle as a tap end suppresses the time-out
    property p_clear_wins;
        @(posedge clk) disable iff (!resetn)
        clear |-> !expire;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("expiry despite clear");

    // read data stand only in the cycle after a read strobe
    property p_rdata_idle;
        @(posedge clk) disable iff (!resetn)
        !rd |=> (rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    // configuration reads show the select field and zero above it
    property p_cfg_read;
        @(posedge clk) disable iff (!resetn)
        (rd && addr == WDP_OFF_CFGH) |=> (rdata[7:5] == 3'h0 && rdata[4:1] == $past(cfgh_q[4:1]));
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("configuration read wrong");

    // running time-out flag stays until written with a one
    property p_rst_sticky;
        @(posedge clk) disable iff (!resetn)
        (stat_q[WDP_ST_RST] && !(wr_st && wdata[WDP_ST_RST])) |=> stat_q[WDP_ST_RST];
    endproperty
    a_rst_sticky: assert property (p_rst_sticky) else $error("reset flag lost");

    // sleeping time-out flag stays until written with a one
    property p_wake_sticky;
        @(posedge clk) disable iff (!resetn)
        (stat_q[WDP_ST_WAKE] && !(wr_st && wdata[WDP_ST_WAKE])) |=> stat_q[WDP_ST_WAKE];
    endproperty
    a_wake_sticky: assert property (p_wake_sticky) else $error("wake flag lost");

    // the sleep instruction puts the device to sleep
    property p_sleep_enter;
        @(posedge clk) disable iff (!resetn)
        (wr_cmd && wdata[WDP_CMD_SLEEP]) |=> asleep;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    // a time-out is a single-cycle pulse
    property p_expire_pulse;
        @(posedge clk) disable iff (!resetn)
        expire |=> !expire;
    endproperty
    a_expire_pulse: assert property (p_expire_pulse) else $error("time-out longer than one cycle");

    // oscillator control keeps what was written
    property p_osc_store;
        @(posedge clk) disable iff (!resetn)
        wr_osc |=> (osc_q == $past(wdata));
    endproperty
    a_osc_store: assert property (p_osc_store) else $error("oscillator control not stored");

    // clearing the software bit cannot stop a configuration-enabled watchdog
    property p_sw_ignored;
        @(posedge clk) disable iff (!resetn)
        (cfgh_q[WDP_CFGEN_BIT] && wr_sw && !wdata[WDP_SWEN_BIT]) |=> lf_osc_en;
    endproperty
    a_sw_ignored: assert property (p_sw_ignored) else $error("software bit overrode configuration");
endmodule
`default_nettype wire

// ### dv/wdp_top_tb.sv
// testbench: registers, time-out timing, clears, enables, sleep wake and interrupt of the watchdog
`default_nettype none
module wdp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdp_pkg::*;
    localparam int TOL = 12; // slack for synchroniser and oscillator phase
    localparam int PER = WDP_BASE_TICKS * 4; // base period in clocks, oscillator period is four clocks
    logic clk = 1'b0; // system clock
    logic resetn = 1'b0; // reset, active low
    logic lf_osc_clk = 1'b0; // fast stand-in for the low-frequency oscillator
    logic clk_fail = 1'b0; // clock failure level
    logic [3:0] addr = 4'h0; // register address
    logic [7:0] wdata = 8'h00; // write data
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic [7:0] rdata; // read data
    logic lf_osc_en, wdt_reset, wdt_wake, asleep, irq; // design outputs
    int mismatches = 0; // failed comparisons
    int num_checks = 0; // comparisons made
    int cycles = 0; // run length guard
    int seed = 32'h96ab; // fixed seed
    int n; // measured cycles
    logic w; // time-out came as wake
    logic [7:0] r, rv; // read value, random value
    logic [3:0] osc_v = 4'h0; // last frequency select written

    // clocks: the oscillator free runs
    always #12.5 clk = ~clk;
    always #50 lf_osc_clk = ~lf_osc_clk;

    wdp_top dut (.clk(clk), .resetn(resetn), .lf_osc_clk(lf_osc_clk), .clk_fail(clk_fail), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lf_osc_en(lf_osc_en), .wdt_reset(wdt_reset),
        .wdt_wake(wdt_wake), .asleep(asleep), .irq(irq));

    // one-cycle register write
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // cycles until a time-out pulse, or lim if none
    task automatic measure(input int lim, output int cnt, output logic wake);
        cnt = 0;
        wake = 1'b0;
        while (cnt < lim) begin
            @(negedge clk);
            cnt++;
            if (wdt_reset === 1'b1 || wdt_wake === 1'b1) begin
                wake = wdt_wake;
                break;
            end
        end
    endtask

    // compare a register value
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    // compare a flag
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // compare a cycle count against a window
    task automatic chk_time(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("mismatch at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask

    // closing report
    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk1(lf_osc_en, 1'b1);
        rd_reg(WDP_OFF_SWCTL, r);
        chk8(r, 8'h00);
        rd_reg(WDP_OFF_CFGH, r);
        chk8(r, WDP_CFGH_RST);
        rd_reg(4'hF, r);
        chk8(r, 8'h00);
        // random control writes: only the enable bit reads back
        repeat (6) begin
            rv = 8'($random(seed));
            wr_reg(WDP_OFF_SWCTL, rv);
            rd_reg(WDP_OFF_SWCTL, r);
            chk8(r, {7'h00, rv[0]});
        end
        // both enables off: oscillator off, no time-out
        wr_reg(WDP_OFF_SWCTL, 8'h00);
        wr_reg(WDP_OFF_CFGH, 8'h00);
        @(negedge clk);
        chk1(lf_osc_en, 1'b0);
        measure(800, n, w);
        chk_time(n, 800, 800);
        // software enable alone runs the base period
        wr_reg(WDP_OFF_SWCTL, 8'h01);
        wr_reg(WDP_OFF_CMD, 8'h01);
        chk1(lf_osc_en, 1'b1);
        measure(3000, n, w);
        chk_time(n, PER - TOL, PER + TOL);
        chk1(w, 1'b0);
        // configuration enable with software bit off, taps 0 to 2
        wr_reg(WDP_OFF_SWCTL, 8'h00);
        for (int s = 0; s < 3; s++) begin
            wr_reg(WDP_OFF_CFGH, 8'(s * 2 + 1));
            wr_reg(WDP_OFF_CMD, 8'h01);
            measure(5000, n, w);
            chk_time(n, (PER << s) - TOL, (PER << s) + TOL);
        end
        rd_reg(WDP_OFF_STATUS, r);
        chk8(r, 8'h01);
        wr_reg(WDP_OFF_STATUS, 8'h01);
        rd_reg(WDP_OFF_STATUS, r);
        chk8(r, 8'h00);
        // each clearing cause restarts the full period from itself
        wr_reg(WDP_OFF_CFGH, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr_reg(WDP_OFF_CMD, 8'h01);
            repeat (300) @(posedge clk);
            case (k)
                0: wr_reg(WDP_OFF_CMD, 8'h01);
                1: begin
                    rv = 8'($random(seed));
                    osc_v = osc_v ^ (rv[3:0] | 4'h1);
                    wr_reg(WDP_OFF_OSCCTL, {osc_v, 4'h0});
                end
                2: begin
                    clk_fail <= 1'b1;
                    repeat (200) @(posedge clk);
                    clk_fail <= 1'b0;
                end
                default: wr_reg(WDP_OFF_CMD, 8'h02);
            endcase
            measure(3000, n, w);
            chk_time(n, PER - TOL, PER + TOL);
        end
        chk1(asleep, 1'b1);
        chk1(w, 1'b1);
        @(negedge clk);
        chk1(asleep, 1'b0);
        // masked, then unmasked, then cleared interrupt from a wake
        wr_reg(WDP_OFF_MASK, 8'h00);
        wr_reg(WDP_OFF_STATUS, 8'h03);
        wr_reg(WDP_OFF_CMD, 8'h02);
        measure(3000, n, w);
        chk_time(n, PER - TOL, PER + TOL);
        chk1(w, 1'b1);
        @(negedge clk);
        chk1(irq, 1'b0);
        rd_reg(WDP_OFF_STATUS, r);
        chk8(r, 8'h02);
        wr_reg(WDP_OFF_MASK, 8'h02);
        @(negedge clk);
        chk1(irq, 1'b1);
        wr_reg(WDP_OFF_STATUS, 8'h02);
        @(negedge clk);
        chk1(irq, 1'b0);
        // sleep, then leave it by command before any time-out
        wr_reg(WDP_OFF_CMD, 8'h02);
        @(negedge clk);
        chk1(asleep, 1'b1);
        wr_reg(WDP_OFF_CMD, 8'h04);
        @(negedge clk);
        chk1(asleep, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
